// ### hdl/ierb_gate.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Registered request gate: pending AND enable
// ---------------------------------------------------------------
module ierb_gate
  import ierb_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst,
  input  wire ierb_vec_t pend,
  input  wire ierb_vec_t en,
  output var  ierb_vec_t req
);
  // Registered so the top output leaves a flip-flop
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      req <= '0;
    end
    else
    begin
      req <= pend & en;
    end
  end
endmodule : ierb_gate
`default_nettype wire

// ### hdl/ierb_pkg.sv
package ierb_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word per register)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_IEC_0 = 12'h000;
  localparam logic [11:0] OFF_IEC_1 = 12'h004;
  localparam logic [11:0] OFF_IEC_2 = 12'h008;
  localparam logic [11:0] OFF_IEC_3 = 12'h00C;
  localparam logic [11:0] OFF_IEC_4 = 12'h010;
  localparam logic [11:0] OFF_VARIANT = 12'h014;
  localparam int          NUM_REGS = 5;

  // ---------------------------------------------------------------
  // Writable masks (unimplemented bits stay zero)
  // ---------------------------------------------------------------
  localparam logic [15:0] MASK_IEC_0 = 16'h0007;
  localparam logic [15:0] MASK_IEC_1 = 16'hFFDF;
  localparam logic [15:0] MASK_IEC_2 = 16'h601F;
  localparam logic [15:0] MASK_IEC_3 = 16'h7800;
  localparam logic [15:0] MASK_IEC_4 = 16'hC07E;
  localparam logic [15:0] RESET_IEC = 16'h0000;

  // Bits gated by optional modules
  localparam logic [15:0] CAN_BITS_2 = 16'h000C;
  localparam logic [15:0] CAN_BITS_4 = 16'h0040;
  localparam logic [15:0] DAC_BITS_4 = 16'hC000;

  // Variant register field positions
  localparam int VAR_CAN_POS = 0;
  localparam int VAR_DAC_POS = 1;
  localparam logic [1:0] RESET_VARIANT = 2'h3;

  // Carrier for the full enable vector
  typedef struct packed {
    logic [15:0] r4;
    logic [15:0] r3;
    logic [15:0] r2;
    logic [15:0] r1;
    logic [15:0] r0;
  } ierb_vec_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ierb_apb_req_t;

endpackage : ierb_pkg

// ### hdl/ierb_regs.sv
// Overview of operation
// - Set enable passes request, clear blocks it
// - Reg0 bits 2..0: compare1, capture1, ext0
// - Reg1 all 16 bits enable except bit 5, which is absent
// - Reg2 bits 14,13 and 4..0 only
// - CAN enables inert without CAN module
// - Reg3 bits 14..11 only implemented
// - Reg4 bits 15,14 and 6..1 only
// - Unimplemented bits ignore writes, read zero
// - Audio DAC enables inert without DAC
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ierb_regs
  import ierb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire ierb_vec_t   irq_pending,
  output var ierb_vec_t    irq_request
);
  import ierb_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] en_reg [NUM_REGS];  // Enable storage
  logic [1:0]  variant;            // Bit0 CAN present, bit1 DAC present
  ierb_vec_t   en_eff;             // Enables after variant gating
  logic        wr_en;              // Access-phase write
  logic        rd_en;              // Access-phase read
  logic [15:0] next_data;          // Masked write data

  // Implemented-bit mask by register index
  function automatic logic [15:0] impl_mask(input int idx);
    case (idx)
      0:       impl_mask = MASK_IEC_0;
      1:       impl_mask = MASK_IEC_1;
      2:       impl_mask = MASK_IEC_2;
      3:       impl_mask = MASK_IEC_3;
      default: impl_mask = MASK_IEC_4;
    endcase
  endfunction : impl_mask

  // Address decode to index, -1 when not an enable register
  function automatic int addr_idx(input logic [11:0] a);
    case (a)
      OFF_IEC_0: addr_idx = 0;
      OFF_IEC_1: addr_idx = 1;
      OFF_IEC_2: addr_idx = 2;
      OFF_IEC_3: addr_idx = 3;
      OFF_IEC_4: addr_idx = 4;
      default:   addr_idx = -1;
    endcase
  endfunction : addr_idx

  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign next_data = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

  // ---------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------
  // Byte strobes honoured; unwritten lanes keep their value
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        en_reg[i] <= RESET_IEC;
    end
    else if (wr_en && addr_idx(paddr) >= 0)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        if (addr_idx(paddr) == i)
        begin
          // Strobed lanes replaced, others kept; absent bits dropped
          en_reg[i] <= impl_mask(i) &
            (({{8{pstrb[1]}}, {8{pstrb[0]}}} & next_data) |
             (~{{8{pstrb[1]}}, {8{pstrb[0]}}} & en_reg[i]));
        end
    end
  end

  // Variant straps held in a register; software may clear module presence
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      variant <= RESET_VARIANT;
    end
    else if (wr_en && paddr == OFF_VARIANT && pstrb[0])
    begin
      variant <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Variant gating of optional-module enables
  // ---------------------------------------------------------------
  always_comb
  begin
    en_eff.r0 = en_reg[0];
    en_eff.r1 = en_reg[1];
    en_eff.r3 = en_reg[3];
    // CAN enables have no effect when the module is absent
    en_eff.r2 = variant[VAR_CAN_POS] ? en_reg[2] : (en_reg[2] & ~CAN_BITS_2);
    en_eff.r4 = en_reg[4];
    if (!variant[VAR_CAN_POS])
      en_eff.r4 = en_eff.r4 & ~CAN_BITS_4;
    if (!variant[VAR_DAC_POS])
      en_eff.r4 = en_eff.r4 & ~DAC_BITS_4;
  end

  // Request gating in its own registered stage
  ierb_gate u_gate (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pend    (irq_pending),
    .en      (en_eff),
    .req     (irq_request)
  );

  // ---------------------------------------------------------------
  // APB answer: no wait states, read data registered
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && addr_idx(paddr) < 0 && paddr != OFF_VARIANT;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == OFF_VARIANT)
          prdata <= {30'h0, variant};
        else if (addr_idx(paddr) >= 0)
          prdata <= {16'h0000, en_reg[addr_idx(paddr)] & impl_mask(addr_idx(paddr))};
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  reset_clear_a: assert property (@(posedge ref_clk) rst |=> en_reg[1] == 16'h0000 && en_reg[4] == 16'h0000)
    else $error("enables not cleared by reset");
  gate_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_pending.r0[2] && en_eff.r0[2]) |=> irq_request.r0[2])
    else $error("enabled request blocked");
  gate_block_a: assert property (@(posedge ref_clk) disable iff (rst)
    !en_eff.r1[15] |=> !irq_request.r1[15])
    else $error("disabled request passed");
  reg0_mask_a: assert property (@(posedge ref_clk) disable iff (rst) (en_reg[0] & ~16'h0007) == 16'h0000)
    else $error("reg0 spare bit set");
  reg1_bit5_a: assert property (@(posedge ref_clk) disable iff (rst) !en_reg[1][5])
    else $error("reg1 bit 5 set");
  // High lane strobe alone qualifies; the bench only drives lanes 0 and 1
  reg1_hi_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && paddr == OFF_IEC_1 && pstrb[1]) |=> en_reg[1][15:8] == $past(pwdata[15:8]))
    else $error("reg1 high byte write lost");
  reg2_mask_a: assert property (@(posedge ref_clk) disable iff (rst) en_reg[2][12:5] == 8'h00)
    else $error("reg2 spare bits set");
  reg3_mask_a: assert property (@(posedge ref_clk) disable iff (rst) en_reg[3][10:0] == 11'h000 && !en_reg[3][15])
    else $error("reg3 spare bits set");
  reg4_mask_a: assert property (@(posedge ref_clk) disable iff (rst) en_reg[4][13:7] == 7'h00 && !en_reg[4][0])
    else $error("reg4 spare bits set");
  read_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == OFF_IEC_2) |=> prdata[12:5] == 8'h00 && prdata[31:16] == 16'h0000)
    else $error("spare bits read nonzero");
  can_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !variant[VAR_CAN_POS] |=> !irq_request.r2[3] && !irq_request.r2[2] && !irq_request.r4[6])
    else $error("CAN request without module");
  dac_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !variant[VAR_DAC_POS] |=> irq_request.r4[15:14] == 2'b00)
    else $error("DAC request without module");
  wr_cov: cover property (@(posedge ref_clk) wr_en && paddr == OFF_IEC_1);
  rd_cov: cover property (@(posedge ref_clk) rd_en && pready && prdata != 32'h0);
  pass_cov: cover property (@(posedge ref_clk) irq_request.r0[0]);
  err_cov: cover property (@(posedge ref_clk) pslverr && pready);

endmodule : ierb_regs
`default_nettype wire

// ### testbench/test_interrupt_enable_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_enable_regs;
  import ierb_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        ref_clk   = 1'b0;  // 20 MHz core clock
  logic        rst       = 1'b1;  // Sync reset, active high
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [3:0]  pstrb     = 4'h3;  // Only lanes 0 and 1 carry data
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ierb_vec_t   pend      = '0;    // Pending flags from sources
  ierb_vec_t   req;
  ierb_vec_t   ex;                // Expected gated requests
  logic [15:0] msk [5];           // Implemented bits per register
  logic [31:0] q;                 // Last read data
  logic        e;                 // Last error response
  int          err_total = 0;
  int          cmp_count = 0;

  // Free-running clock, 50 ns period
  always #25 ref_clk = ~ref_clk;

  ierb_regs ierb_regs_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pending(pend), .irq_request(req));

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  // One APB transfer; request held until pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Case-equality compare, wide enough for the request vector
  task chk(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  // Gate output lags pending by one edge; allow it to settle
  task chk_gate;
    repeat (3) @(posedge ref_clk);
    chk(req, ex);
  endtask : chk_gate

  task report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    msk = '{MASK_IEC_0, MASK_IEC_1, MASK_IEC_2, MASK_IEC_3, MASK_IEC_4};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    // Everything disabled out of reset
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, OFF_IEC_0 + 12'(4 * i), 32'h0);
      chk(q, 80'h0);
    end
    apb(1'b0, OFF_VARIANT, 32'h0);
    chk(q, {78'h0, RESET_VARIANT});
    // All ones written; absent positions must read zero
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, OFF_IEC_0 + 12'(4 * i), 32'hFFFF_FFFF);
      apb(1'b0, OFF_IEC_0 + 12'(4 * i), 32'h0);
      chk(q, {64'h0, msk[i]});
    end
    // Every source pending: only enabled ones pass
    pend <= '1;
    ex = {msk[4], msk[3], msk[2], msk[1], msk[0]};
    chk_gate();
    // Low byte strobe only: clears the low half of reg1
    pstrb <= 4'h1;
    apb(1'b1, OFF_IEC_1, 32'h0);
    pstrb <= 4'h3;
    apb(1'b0, OFF_IEC_1, 32'h0);
    chk(q, {64'h0, msk[1] & 16'hFF00});
    ex.r1 = msk[1] & 16'hFF00;
    chk_gate();
    // Optional modules absent: their requests are held off
    apb(1'b1, OFF_VARIANT, 32'h0);
    ex.r2 = msk[2] & ~CAN_BITS_2;
    ex.r4 = msk[4] & ~(CAN_BITS_4 | DAC_BITS_4);
    chk_gate();
    apb(1'b0, OFF_IEC_4, 32'h0);
    chk(q, {64'h0, msk[4]});
    // Unmapped place: error response, reads zero
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk(e, 80'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk({e, q}, {47'h0, 1'b1, 32'h0});
    // Pending withdrawn: requests drop
    pend <= '0;
    ex = '0;
    chk_gate();
    // Second reset in mid-run clears all enables
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, OFF_IEC_0 + 12'(4 * i), 32'h0);
      chk(q, 80'h0);
    end
    // Variant straps return to both modules present
    apb(1'b0, OFF_VARIANT, 32'h0);
    chk(q, {78'h0, RESET_VARIANT});
    report_and_stop();
  end

  // Watchdog, far beyond the expected run time
  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule : test_interrupt_enable_regs
`default_nettype wire
